// *** rtl/tcb_pkg.sv ***
// constants shared by the transfer controller bus-ownership logic
package tcb_pkg;
  localparam int STEP_W = 2;
  localparam int CNT_W = 8;
  localparam logic [STEP_W-1:0] STEP_VEC = 2'h0;
  localparam logic [STEP_W-1:0] STEP_INFO = 2'h1;
  localparam logic [STEP_W-1:0] STEP_DATA = 2'h2;
  localparam logic [STEP_W-1:0] STEP_WB = 2'h3;
  localparam logic [CNT_W-1:0] CNT_RESET = 8'h00;
  localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;
  localparam logic BUS_REQ_RESET = 1'b0;
endpackage

// *** rtl/tcb_data_count.sv ***
// remaining single data transfers of the current transfer information
`timescale 1ns/100ps
`default_nettype none
module tcb_data_count
  import tcb_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // control
  input wire logic load,
  input wire logic [CNT_W-1:0] loadVal,
  input wire logic dec,
  // status
  output logic last
);
  logic [CNT_W-1:0] remain;

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      remain <= CNT_RESET;
    end else if (load) begin
      remain <= loadVal;
    end else if (dec && remain != CNT_RESET) begin
      remain <= remain - CNT_ONE;
    end
  end

  // a count of zero is taken as one transfer
  assign last = (remain <= CNT_ONE);
endmodule
`default_nettype wire

// *** rtl/tcb_bus_release.sv ***
// bus-ownership sequencer of the data transfer controller
//
// Summary of operation
// RULE1 - on activation, request internal bus from arbiter before any step
// RULE2 - lock 0 burst 0: keep bus during steps, release after write-back
// RULE3 - lock 0 burst 1: release after normal write-back, keep if continuous
// RULE4 - lock 1 burst 0: release bus after every step
// RULE5 - lock 1 with burst 1 is unsupported; activation refused, fault flagged
// RULE6 - software keeps priority select 0 while lock select is 1
`timescale 1ns/100ps
`default_nettype none
module tcb_bus_release
  import tcb_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // configuration
  input wire logic bus_lock_select,
  input wire logic burst_release_select,
  input wire logic activation_priority_select,
  // activation
  input wire logic actReq,
  // arbiter
  output logic busReq,
  input wire logic busGrant,
  // step datapath
  output logic stepGo,
  output logic [STEP_W-1:0] stepKind,
  input wire logic stepDone,
  input wire logic [CNT_W-1:0] xferCount,
  input wire logic chainNext,
  // status
  output logic busy,
  output logic cfgFault
);
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_REQ,
    ST_GO,
    ST_WAIT,
    ST_REL
  } tcb_state_t;

  tcb_state_t state;
  tcb_state_t next_state;
  logic [STEP_W-1:0] curStep;
  logic [STEP_W-1:0] next_step;
  logic lockCfg;
  logic burstCfg;
  logic lastData;
  logic waitDone;
  logic seqEnd;
  logic relNow;
  logic badCombo;

  // release decision after a finished step
  function automatic logic rel_after(input logic [STEP_W-1:0] step,
                                     input logic lock,
                                     input logic burst,
                                     input logic chain);
    logic r;
    r = 1'b1;
    if (lock) begin
      r = 1'b1; // RULE4
    end else if (step != STEP_WB) begin
      r = 1'b0; // RULE2 RULE3
    end else if (burst) begin
      r = !chain; // RULE3
    end else begin
      r = 1'b1; // RULE2
    end
    return r;
  endfunction

  assign badCombo = bus_lock_select && burst_release_select;
  assign waitDone = (state == ST_WAIT) && stepDone;
  assign seqEnd = (curStep == STEP_WB) && !chainNext;
  assign relNow = rel_after(curStep, lockCfg, burstCfg, chainNext);

  tcb_data_count u_count (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .load(waitDone && curStep == STEP_INFO),
    .loadVal(xferCount),
    .dec(waitDone && curStep == STEP_DATA),
    .last(lastData)
  );

  // next step of the transfer sequence
  always_comb begin
    next_step = curStep;
    if (state == ST_IDLE) begin
      next_step = STEP_VEC;
    end else if (waitDone) begin
      unique case (curStep)
        STEP_VEC: next_step = STEP_INFO;
        STEP_INFO: next_step = STEP_DATA;
        STEP_DATA: next_step = lastData ? STEP_WB : STEP_DATA;
        STEP_WB: next_step = STEP_INFO;
      endcase
    end
  end

  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE: begin
        if (actReq && !badCombo) begin
          next_state = ST_REQ; // RULE1 RULE5
        end
      end
      ST_REQ: begin
        if (busGrant) begin
          next_state = ST_GO;
        end
      end
      ST_GO: next_state = ST_WAIT;
      ST_WAIT: begin
        if (stepDone) begin
          if (seqEnd) begin
            next_state = ST_IDLE;
          end else if (relNow) begin
            next_state = ST_REL;
          end else begin
            next_state = ST_GO;
          end
        end
      end
      ST_REL: next_state = ST_REQ;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      state <= ST_IDLE;
      curStep <= STEP_VEC;
    end else begin
      state <= next_state;
      curStep <= next_step;
    end
  end

  // configuration is held for a whole activation
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      lockCfg <= 1'b0;
      burstCfg <= 1'b0;
    end else if (state == ST_IDLE) begin
      lockCfg <= bus_lock_select;
      burstCfg <= burst_release_select;
    end
  end

  // bus request held from activation until a release point
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      busReq <= BUS_REQ_RESET;
    end else begin
      busReq <= (next_state == ST_REQ) || (next_state == ST_GO) ||
                (next_state == ST_WAIT); // RULE1
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      stepGo <= 1'b0;
      stepKind <= STEP_VEC;
    end else begin
      stepGo <= (next_state == ST_GO) && busGrant; // RULE1
      stepKind <= next_step;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      busy <= 1'b0;
      cfgFault <= 1'b0;
    end else begin
      busy <= (next_state != ST_IDLE);
      cfgFault <= badCombo ||
                  (bus_lock_select && activation_priority_select); // RULE5 RULE6
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  sequence grantSeq;
    state == ST_REQ && busGrant;
  endsequence

  sequence stepIssue;
    stepGo && busReq;
  endsequence

  act_requests_bus_a: assert property ( // RULE1
    state == ST_IDLE && actReq && !badCombo |=> busReq && state == ST_REQ)
    else $error("activation did not request the bus");

  grant_starts_step_a: assert property ( // RULE1
    grantSeq |=> stepIssue)
    else $error("grant not followed by a step");

  step_needs_bus_a: assert property ( // RULE1
    stepGo |-> busReq && $past(busGrant))
    else $error("step issued without bus");

  hold_mid_seq_a: assert property ( // RULE2
    waitDone && !lockCfg && curStep != STEP_WB |=> busReq && stepGo)
    else $error("bus released before write-back");

  wb_release_a: assert property ( // RULE2
    waitDone && !lockCfg && !burstCfg && curStep == STEP_WB
    |=> !busReq)
    else $error("bus kept after write-back");

  burst_keep_a: assert property ( // RULE3
    waitDone && !lockCfg && burstCfg && curStep == STEP_WB && chainNext
    |=> busReq && stepGo && stepKind == STEP_INFO)
    else $error("continuous burst lost the bus");

  burst_normal_rel_a: assert property ( // RULE3
    waitDone && !lockCfg && burstCfg && curStep == STEP_WB && !chainNext
    |=> !busReq && !busy)
    else $error("normal burst kept the bus");

  lock_release_a: assert property ( // RULE4
    waitDone && lockCfg |=> !busReq ##1 (busReq || !busy))
    else $error("locked setting did not release the bus");

  combo_refused_a: assert property ( // RULE5
    state == ST_IDLE && actReq && badCombo |=> !busReq && cfgFault)
    else $error("unsupported setting was accepted");
endmodule
`default_nettype wire

// *** sim/tcb_arb_model.sv ***
// internal bus arbiter model with adjustable grant delay
`timescale 1ns/100ps
`default_nettype none
module tcb_arb_model (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // request and grant
  input wire logic busReq,
  input wire logic [3:0] grantDelay,
  output logic busGrant
);
  logic [3:0] waitCnt;
  // grant withdrawn at the clock edge after the request drops
  always_ff @(posedge clk_sys) begin
    if (!rst_b || !busReq) begin
      waitCnt <= 4'h0;
      busGrant <= 1'b0;
    end else if (waitCnt >= grantDelay) begin
      busGrant <= 1'b1;
    end else begin
      waitCnt <= waitCnt + 4'h1;
    end
  end
endmodule
`default_nettype wire

// *** sim/tb.sv ***
// self-checking bench for the bus-ownership sequencer
`timescale 1ns/100ps
`default_nettype none
module tb;
  import tcb_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic lock = 1'b0;
  logic burst = 1'b0;
  logic prio = 1'b0;
  logic actReq = 1'b0;
  logic stepDone = 1'b0;
  logic chainNext = 1'b0;
  logic lastReq = 1'b0;
  logic [CNT_W-1:0] xferCount = CNT_ONE;
  logic [3:0] grantDelay = 4'h0;
  logic busReq, busGrant, stepGo, busy, cfgFault;
  logic [STEP_W-1:0] stepKind;
  int fails = 0, tests_run = 0, falls = 0, gos = 0, cycles = 0;
  tcb_bus_release tcb_bus_release_inst (.clk_sys(clk_sys), .rst_b(rst_b),
    .bus_lock_select(lock), .burst_release_select(burst),
    .activation_priority_select(prio), .actReq(actReq), .busReq(busReq),
    .busGrant(busGrant), .stepGo(stepGo), .stepKind(stepKind),
    .stepDone(stepDone), .xferCount(xferCount), .chainNext(chainNext),
    .busy(busy), .cfgFault(cfgFault));
  tcb_arb_model tcb_arb_model_inst (.clk_sys(clk_sys), .rst_b(rst_b),
    .busReq(busReq), .grantDelay(grantDelay), .busGrant(busGrant));
  initial begin
    forever #10 clk_sys = ~clk_sys;
  end
  task automatic chk(input logic got, input logic exp, input string msg);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t %s", $time, msg);
    end
  endtask
  task automatic chkKind(input logic [STEP_W-1:0] got,
                         input logic [STEP_W-1:0] exp, input string msg);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t %s got %0h want %0h", $time, msg, got, exp);
    end
  endtask
  task automatic chkCnt(input int got, input int exp, input string msg);
    tests_run++;
    if (got != exp) begin
      fails++;
      $display("ERROR %0t %s got %0d want %0d", $time, msg, got, exp);
    end
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    lastReq <= busReq;
    if (lastReq === 1'b1 && busReq === 1'b0) falls <= falls + 1;
    if (stepGo === 1'b1) begin
      gos <= gos + 1;
      chk(busReq & busGrant, 1'b1, "step without bus");
    end
    if (cycles == 20000) begin
      fails++;
      results();
    end
  end
  task automatic run(input logic l, input logic b, input int n,
                     input int chains, input int dly, input string name);
    int c, i, g, f;
    int left;
    logic wb;
    logic [STEP_W-1:0] ek;
    g = 1 + (chains + 1) * ((n == 0 ? 1 : n) + 2);
    f = l ? g : (b ? 1 : chains + 1);
    lock = l;
    burst = b;
    xferCount = n[CNT_W-1:0];
    grantDelay = dly[3:0];
    falls = 0;
    gos = 0;
    c = chains;
    i = 0;
    left = 0;
    ek = STEP_VEC;
    actReq = 1'b1;
    @(posedge clk_sys);
    #1 actReq = 1'b0;
    while (busy === 1'b1 && i < 400) begin
      if (stepGo === 1'b1) begin
        chkKind(stepKind, ek, "step order");
        wb = (ek == STEP_WB);
        @(posedge clk_sys);
        #1 stepDone = 1'b1;
        chainNext = wb && c > 0;
        @(posedge clk_sys);
        #1 stepDone = 1'b0;
        chainNext = 1'b0;
        if (wb) c--;
        if (ek == STEP_VEC) begin
          ek = STEP_INFO;
        end else if (ek == STEP_INFO) begin
          ek = STEP_DATA;
          left = (n == 0) ? 1 : n;
        end else if (ek == STEP_DATA) begin
          left--;
          if (left == 0) ek = STEP_WB;
        end else begin
          ek = STEP_INFO;
        end
      end else begin
        @(posedge clk_sys);
        #1;
      end
      i++;
    end
    repeat (2) @(posedge clk_sys);
    #1 chkCnt(gos, g, "step count");
    chkCnt(falls, f, "bus releases");
    chk(busReq, 1'b0, "bus kept at end");
    $display("test %s done", name);
  endtask
  task automatic refused();
    lock = 1'b1;
    burst = 1'b1;
    actReq = 1'b1;
    repeat (2) @(posedge clk_sys);
    #1 chk(cfgFault, 1'b1, "no fault flag");
    chk(busReq, 1'b0, "bus requested");
    chk(busy, 1'b0, "activation taken");
    actReq = 1'b0;
    burst = 1'b0;
    prio = 1'b1;
    @(posedge clk_sys);
    #1 chk(cfgFault, 1'b1, "priority with lock not flagged");
    lock = 1'b0;
    prio = 1'b0;
    repeat (2) @(posedge clk_sys);
    #1 chk(cfgFault, 1'b0, "fault flag stuck");
    $display("test refused done");
  endtask
  initial begin
    repeat (20) @(posedge clk_sys);
    #1 rst_b = 1'b1;
    @(posedge clk_sys);
    #1 run(1'b0, 1'b0, 1, 1, 0, "hold_chain");
    run(1'b0, 1'b1, 2, 1, 3, "burst_chain");
    run(1'b0, 1'b1, 1, 0, 1, "burst_normal");
    run(1'b1, 1'b0, 2, 1, 2, "lock_each");
    run(1'b0, 1'b0, 0, 0, 0, "zero_count");
    refused();
    results();
  end
endmodule
`default_nettype wire
